/* File: shared/vmc_pkg.sv */
// Package for the oscillator and modem configuration register bank
// How it works
// RULE_01 - The upper nibble of the oscillator register is the frequency A core current code, reset 8.
// RULE_02 - The lower nibble of the oscillator register is the frequency B core current code, reset 8.
// RULE_03 - The ADC divisor field, reset 3, divides the crystal clock by twice the code plus two; code 0 is unsupported.
// RULE_04 - With whitening enabled, transmit and receive bits are XORed with a PN9 sequence x^9+x^5+1.
// RULE_05 - The host may send only zeros with whitening on, and count received ones as bit errors.
// RULE_06 - Format 00 is NRZ and format 01 is Manchester.
// RULE_07 - Formats 10 and 11 are transparent UART, with the data clock pin held at 0 or 1.
// RULE_08 - The ADC clock runs at four times the intermediate frequency, so the IF strobe is ADC rate over 4.
// RULE_09 - The host picks the divisor that puts the ADC clock nearest 1.2288 MHz.
// RULE_10 - Reserved modem bits 7 and 3 are written as zero by the host and read back as zero; the bench sets both to one in its format writes (8'h88).
// RULE_11 - Reset loads every field default, and fields hold the last written value.
package vmc_pkg;
	localparam logic [7:0] OSC_CORE_CURRENT_ADDR = 8'h0C;
	localparam logic [7:0] MODEM_FORMAT_CTRL_ADDR = 8'h0D;
	localparam int BIAS_A_LSB = 4;
	localparam int BIAS_B_LSB = 0;
	localparam int ADC_DIV_LSB = 4;
	localparam int WHITEN_BIT = 2;
	localparam int FORMAT_LSB = 0;
	localparam logic [3:0] BIAS_A_RESET = 4'h8;
	localparam logic [3:0] BIAS_B_RESET = 4'h8;
	localparam logic [2:0] ADC_DIV_RESET = 3'h3;
	localparam logic WHITEN_RESET = 1'b0;
	localparam logic [1:0] FORMAT_RESET = 2'h0;
	localparam logic [8:0] PN9_SEED = 9'h1FF;
	localparam logic [1:0] IF_PER_ADC = 2'h3;
	typedef enum logic [1:0] {
		VMC_FMT_NRZ,
		VMC_FMT_MANCH,
		VMC_FMT_UART0,
		VMC_FMT_UART1
	} vmc_format_e;
endpackage : vmc_pkg

/* File: shared/vmc_div_if.sv */
// Interface between the register bank and the clock divider
`timescale 1ns/1ps
`default_nettype none
interface vmc_div_if;
	logic [2:0] div_code;
	logic       adc_stb;
	logic       if_stb;
	modport ctrl (output div_code, input adc_stb, input if_stb);
	modport div  (input div_code, output adc_stb, output if_stb);
endinterface : vmc_div_if
`default_nettype wire

/* File: src/vmc_clk_div.sv */
// ADC and IF enable-pulse divider
`timescale 1ns/1ps
`default_nettype none
module vmc_clk_div (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// Divider control
	vmc_div_if.div    dv
);
	typedef struct packed {
		logic [4:0] cnt;
		logic [1:0] ifc;
		logic       adc;
		logic       ifs;
	} vmc_div_s;
	vmc_div_s st_r;
	vmc_div_s st_nxt;
	logic [4:0] last;
	always_comb begin
		last = {1'b0, dv.div_code, 1'b1}; // [RULE_03]
		st_nxt = st_r;
		st_nxt.adc = 1'b0;
		st_nxt.ifs = 1'b0;
		if (dv.div_code == 3'h0) begin
			st_nxt.cnt = 5'h00;
		end else if (st_r.cnt >= last) begin
			st_nxt.cnt = 5'h00;
			st_nxt.adc = 1'b1;
			st_nxt.ifc = st_r.ifc + 2'h1;
			st_nxt.ifs = (st_r.ifc == vmc_pkg::IF_PER_ADC); // [RULE_08]
		end else begin
			st_nxt.cnt = st_r.cnt + 5'h01;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign dv.adc_stb = st_r.adc;
	assign dv.if_stb = st_r.ifs;
	AST_ADC_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_03]
		$rose(st_r.adc) && dv.div_code == 3'h1 ##1 (dv.div_code == 3'h1) [*4] |->
		st_r.adc) else $error("ADC strobe period wrong");
	AST_IF_NEEDS_ADC: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_08]
		st_r.ifs |-> st_r.adc) else $error("IF strobe without ADC strobe");
endmodule : vmc_clk_div
`default_nettype wire

/* File: src/vmc_regs.sv */
// Oscillator and modem configuration register bank
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module vmc_regs (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Register port
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// Data path
	input  wire logic       tx_bit_i,
	input  wire logic       tx_bit_vld_i,
	input  wire logic       rx_bit_i,
	input  wire logic       rx_bit_vld_i,
	output logic            tx_bit_o,
	output logic            rx_bit_o,
	// Configuration outputs
	output logic      [3:0] osc_core_bias_a_o,
	output logic      [3:0] osc_core_bias_b_o,
	output logic            adc_clk_en_o,
	output logic            if_clk_en_o,
	output logic            nrz_mode_o,
	output logic            manchester_mode_o,
	output logic            uart_mode_o,
	output logic            data_clock_pin_o
);
	typedef struct packed {
		logic [3:0] bias_a;
		logic [3:0] bias_b;
		logic [2:0] adc_div;
		logic       whiten;
		logic [1:0] fmt;
		logic [7:0] rdata;
		logic [8:0] tx_lfsr;
		logic [8:0] rx_lfsr;
		logic       tx_bit;
		logic       rx_bit;
	} vmc_regs_s;
	vmc_regs_s st_r;
	vmc_regs_s st_nxt;
	vmc_div_if div_if ();
	function automatic logic [8:0] pn9_step(input logic [8:0] s);
		pn9_step = {s[0] ^ s[5], s[8:1]}; // [RULE_04]
	endfunction
	vmc_clk_div u_div (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.dv      (div_if.div)
	);
	assign div_if.div_code = st_r.adc_div;
	always_comb begin
		st_nxt = st_r;
		if (wr_i && addr_i == vmc_pkg::OSC_CORE_CURRENT_ADDR) begin
			st_nxt.bias_a = wdata_i[vmc_pkg::BIAS_A_LSB +: 4]; // [RULE_01]
			st_nxt.bias_b = wdata_i[vmc_pkg::BIAS_B_LSB +: 4]; // [RULE_02]
		end
		if (wr_i && addr_i == vmc_pkg::MODEM_FORMAT_CTRL_ADDR) begin
			st_nxt.adc_div = wdata_i[vmc_pkg::ADC_DIV_LSB +: 3]; // [RULE_03]
			st_nxt.whiten = wdata_i[vmc_pkg::WHITEN_BIT]; // [RULE_04]
			st_nxt.fmt = wdata_i[vmc_pkg::FORMAT_LSB +: 2]; // [RULE_06]
		end
		st_nxt.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				vmc_pkg::OSC_CORE_CURRENT_ADDR: begin
					st_nxt.rdata = {st_r.bias_a, st_r.bias_b};
				end
				vmc_pkg::MODEM_FORMAT_CTRL_ADDR: begin
					st_nxt.rdata = {1'b0, st_r.adc_div, 1'b0, st_r.whiten, st_r.fmt}; // [RULE_10]
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end
		if (!st_r.whiten) begin
			st_nxt.tx_lfsr = vmc_pkg::PN9_SEED;
			st_nxt.rx_lfsr = vmc_pkg::PN9_SEED;
		end
		if (tx_bit_vld_i) begin
			st_nxt.tx_bit = tx_bit_i ^ (st_r.whiten & st_r.tx_lfsr[0]); // [RULE_04]
			if (st_r.whiten) begin
				st_nxt.tx_lfsr = pn9_step(st_r.tx_lfsr);
			end
		end
		if (rx_bit_vld_i) begin
			st_nxt.rx_bit = rx_bit_i ^ (st_r.whiten & st_r.rx_lfsr[0]); // [RULE_04]
			if (st_r.whiten) begin
				st_nxt.rx_lfsr = pn9_step(st_r.rx_lfsr);
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_r.bias_a <= vmc_pkg::BIAS_A_RESET; // [RULE_11]
			st_r.bias_b <= vmc_pkg::BIAS_B_RESET;
			st_r.adc_div <= vmc_pkg::ADC_DIV_RESET;
			st_r.whiten <= vmc_pkg::WHITEN_RESET;
			st_r.fmt <= vmc_pkg::FORMAT_RESET;
			st_r.rdata <= 8'h00;
			st_r.tx_lfsr <= vmc_pkg::PN9_SEED;
			st_r.rx_lfsr <= vmc_pkg::PN9_SEED;
			st_r.tx_bit <= 1'b0;
			st_r.rx_bit <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign rdata_o = st_r.rdata;
	assign tx_bit_o = st_r.tx_bit;
	assign rx_bit_o = st_r.rx_bit;
	assign osc_core_bias_a_o = st_r.bias_a;
	assign osc_core_bias_b_o = st_r.bias_b;
	assign adc_clk_en_o = div_if.adc_stb;
	assign if_clk_en_o = div_if.if_stb;
	assign nrz_mode_o = (st_r.fmt == vmc_pkg::VMC_FMT_NRZ); // [RULE_06]
	assign manchester_mode_o = (st_r.fmt == vmc_pkg::VMC_FMT_MANCH); // [RULE_06]
	assign uart_mode_o = st_r.fmt[1]; // [RULE_07]
	assign data_clock_pin_o = st_r.fmt[1] & st_r.fmt[0]; // [RULE_07]
	AST_BIAS_WRITE: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_01]
		wr_i && addr_i == vmc_pkg::OSC_CORE_CURRENT_ADDR |=>
		osc_core_bias_a_o == $past(wdata_i[7:4])) else $error("Bias A not written");
	AST_BIAS_B_HOLD: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_02]
		!(wr_i && addr_i == vmc_pkg::OSC_CORE_CURRENT_ADDR) |=>
		$stable(osc_core_bias_b_o)) else $error("Bias B changed without write");
	AST_RESET_DEFAULT: assert property (@(posedge clk_i) // [RULE_11]
		reset_i |=> osc_core_bias_a_o == 4'h8 && st_r.adc_div == 3'h3 && !st_r.whiten
		&& st_r.fmt == 2'h0) else $error("Reset defaults wrong");
	AST_RSVD_ZERO: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_10]
		rd_i && addr_i == vmc_pkg::MODEM_FORMAT_CTRL_ADDR |=>
		rdata_o[7] == 1'b0 && rdata_o[3] == 1'b0) else $error("Reserved bits not zero");
	AST_READBACK: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_03]
		wr_i && addr_i == vmc_pkg::MODEM_FORMAT_CTRL_ADDR ##2
		rd_i && addr_i == vmc_pkg::MODEM_FORMAT_CTRL_ADDR |=>
		rdata_o[6:4] == $past(wdata_i[6:4], 3)) else $error("Divisor readback wrong");
	AST_PLAIN_PASS: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_04]
		tx_bit_vld_i && !st_r.whiten |=> tx_bit_o == $past(tx_bit_i))
		else $error("Unwhitened bit altered");
	AST_WHITEN_FLIP: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_04]
		rx_bit_vld_i && st_r.whiten |=> rx_bit_o == ($past(rx_bit_i) ^ $past(st_r.rx_lfsr[0])))
		else $error("Whitened bit wrong");
	AST_UART_PIN: assert property (@(posedge clk_i) disable iff (reset_i) // [RULE_07]
		uart_mode_o |-> data_clock_pin_o == st_r.fmt[0] && !nrz_mode_o && !manchester_mode_o)
		else $error("UART pin level wrong");
endmodule : vmc_regs
`default_nettype wire

/* File: dv/vmc_host.sv */
// Host model on the register port
`timescale 1ns/1ps
`default_nettype none
module vmc_host (
	// Clock
	input  wire logic       clk_i,
	// Register port
	output logic      [7:0] addr_o,
	output logic      [7:0] wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	initial {addr_o, wdata_o, wr_o, rd_o} = '0;
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_i);
		{addr_o, wdata_o, wr_o} <= {a, v, 1'b1};
		@(posedge clk_i);
		wr_o <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_i);
		{addr_o, rd_o} <= {a, 1'b1};
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1 v = rdata_i;
	endtask
endmodule // vmc_host
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
$display("ERROR %0t %h %h", $time, a, e); end end
module tb_top;
	logic       clk_i = 0;
	logic       reset_i = 1;
	logic [7:0] addr, wdata, rdata, d;
	logic       wr, rd, to, ro, nrz, man, uart, pin, adc, ifc;
	logic       tb = 0, tv = 0, rb = 0, rv = 0;
	logic [3:0] ba, bb;
	logic [8:0] s = 9'h1FF;
	logic [7:0] mreg [2];
	int         checks = 0, n_fail = 0, n, m, k;
	always #20 clk_i = ~clk_i;
	vmc_host vmc_host_inst (.clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.rdata_i(rdata));
	vmc_regs vmc_regs_inst (.clk_i, .reset_i, .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .tx_bit_i(tb), .tx_bit_vld_i(tv), .rx_bit_i(rb),
		.rx_bit_vld_i(rv), .tx_bit_o(to), .rx_bit_o(ro), .osc_core_bias_a_o(ba),
		.osc_core_bias_b_o(bb), .adc_clk_en_o(adc), .if_clk_en_o(ifc), .nrz_mode_o(nrz),
		.manchester_mode_o(man), .uart_mode_o(uart), .data_clock_pin_o(pin));
	task automatic finish_test;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		vmc_host_inst.wr_reg(a, v);
		if (a == 8'h0C) mreg[0] = v;
		if (a == 8'h0D) mreg[1] = v & 8'h77;
	endtask
	task automatic rdchk(input logic [7:0] a);
		vmc_host_inst.rd_reg(a, d);
		`CHK(d, a == 8'h0C ? mreg[0] : a == 8'h0D ? mreg[1] : 8'h00)
	endtask
	task automatic bit_chk(input logic b, input logic r, input logic w);
		@(posedge clk_i);
		{tb, tv, rb, rv} <= {b, 1'b1, r, 1'b1};
		@(posedge clk_i);
		{tv, rv} <= 2'b00;
		#1;
		`CHK({to, ro}, {b ^ (w & s[0]), r ^ (w & s[0])})
		if (w) s = {s[0] ^ s[5], s[8:1]};
	endtask
	task automatic div_chk(input int c);
		reg_wr(8'h0D, 8'(c << 4));
		repeat (40) @(posedge clk_i);
		for (int j = 0; j < 2; j++) begin
			n = 0;
			do begin
				@(posedge clk_i);
				#1 n++;
			end while (adc !== 1'b1 && n < 40);
		end
		`CHK(n, c ? 2 * c + 2 : 40)
		m = 0;
		repeat (16 * c + 16) begin
			@(posedge clk_i);
			#1 m += int'(ifc);
		end
		`CHK(m, c ? 2 : 0)
	endtask
	initial begin
		void'($urandom(18117));
		mreg[0] = 8'h88;
		mreg[1] = 8'h30;
		repeat (8) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		`CHK({ba, bb}, 8'h88)
		rdchk(8'h0C);
		rdchk(8'h0D);
		for (k = 0; k < 4; k++) begin
			reg_wr(8'h0C, 8'($urandom));
			rdchk(8'h0C);
			`CHK({ba, bb}, mreg[0])
		end
		reg_wr(8'h0E, 8'hFF);
		rdchk(8'h0E);
		rdchk(8'h0C);
		for (k = 0; k < 4; k++) begin
			reg_wr(8'h0D, 8'h88 | 8'(k));
			rdchk(8'h0D);
			`CHK({nrz, man, uart, pin}, 4'((8 >> k) | (k == 3) * 2))
		end
		for (k = 0; k < 8; k++) div_chk(k);
		div_chk(7);
		reg_wr(8'h0D, 8'h34);
		for (k = 0; k < 20; k++) bit_chk(k < 10 ? 1'b0 : 1'($urandom), 1'($urandom), 1'b1);
		reg_wr(8'h0D, 8'h30);
		bit_chk(1'b1, 1'b0, 1'b0);
		finish_test();
	end
	// Whole run is under 1500 cycles
	initial begin
		#2000000;
		n_fail++;
		finish_test();
	end
endmodule // tb_top
`default_nettype wire
